// >>> rcx_core.sv
// Purpose: 8-bit core with two-stage pipeline and four-phase cycles.
// Assumes: Program and data memories answer within the same clock.
// Notes:   Bit-test opcodes are not decoded and execute as no-ops.
`default_nettype none
module rcx_core (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Program memory
    output logic      [10:0]        prog_addr,
    output logic                    prog_ram_sel,
    input  wire logic [11:0]        prog_rdata,
    // Data memory
    output var rcx_pkg::rcx_dreq_s  dmem_req,
    input  wire logic [7:0]         dmem_rdata,
    // Peripheral port
    output var rcx_pkg::rcx_dreq_s  periph_req,
    input  wire logic [7:0]         periph_rdata,
    input  wire logic               periph_irq,
    input  wire logic               smb_slave_busy,
    // Timer pins
    input  wire logic               timer_a_count_pin,
    input  wire logic               clk_32k_pin,
    // Status
    output logic                    osc_run,
    output logic                    sleeping,
    output logic                    timer_b_irq
);
    // ************************************************
    // State
    // ************************************************
    rcx_pkg::rcx_phase_e ph_q, ph_d;
    rcx_pkg::rcx_cfg_s   cfg_q;
    logic [10:0] pc_q, pc_d;
    logic [11:0] ir_q;
    logic [7:0]  w_q, fsp_q, status_q, opnd_q, res_q;
    logic [7:0]  eff_q;
    logic [2:0]  flg_q;
    logic        sleep_q;
    logic [11:0] stk_top;
    logic [7:0]  ta_count;
    logic        tb_ovf;
    // ************************************************
    // Decode
    // ************************************************
    wire [5:0] op6     = ir_q[11:6];
    wire [3:0] op4     = ir_q[11:8];
    wire [7:0] lit     = ir_q[7:0];
    wire       is_file = op4 <= rcx_pkg::OP4_FILE_TOP;
    wire       is_alu  = is_file && op6 != rcx_pkg::ALU_MOVWF;
    wire       is_spec = is_file && op6 == rcx_pkg::ALU_MOVWF && !ir_q[5];
    wire       is_lit  = op4 >= rcx_pkg::OP4_MOVLW;
    wire       is_goto = ir_q[11:9] == rcx_pkg::OP3_GOTO;
    wire       is_call = op4 == rcx_pkg::OP4_CALL;
    wire       is_rlw  = op4 == rcx_pkg::OP4_RETURN_WITH_LITERAL;
    wire       is_ret  = ir_q == rcx_pkg::OP_RETURN;
    wire       is_opt  = ir_q == rcx_pkg::OP_OPTION;
    wire       is_slp  = ir_q == rcx_pkg::OP_SLEEP;
    wire       branch  = is_goto || is_call || is_ret || is_rlw;
    wire       wb_file = is_file && !is_spec && ir_q[5];
    wire       wb_w    = (is_alu && !ir_q[5]) || is_lit;
    wire [5:0] lit_op  = (op4 == rcx_pkg::OP4_MOVLW) ? rcx_pkg::ALU_MOV :
                         (op4 == rcx_pkg::OP4_IORLW) ? rcx_pkg::ALU_IOR :
                         (op4 == rcx_pkg::OP4_ANDLW) ? rcx_pkg::ALU_AND :
                         rcx_pkg::ALU_XOR;
    wire [5:0] alu_op  = is_lit ? lit_op : op6;
    wire [7:0] alu_b   = is_lit ? lit : opnd_q;
    wire [4:0] fa_dec  = (ir_q[4:0] == rcx_pkg::FA_INDIRECT) ? fsp_q[4:0] : ir_q[4:0];
    wire [4:0] fa      = eff_q[4:0];
    wire       at_ta   = fa == rcx_pkg::FA_TIMER_A;
    wire       at_pc   = fa == rcx_pkg::FA_PC_LOW;
    wire       at_st   = fa == rcx_pkg::FA_STATUS;
    wire       at_fsp  = fa == rcx_pkg::FA_FSP;
    wire       at_per  = fa == rcx_pkg::FA_PERIPH;
    wire       at_int  = at_ta || at_pc || at_st || at_fsp || at_per;
    wire       ph_rd   = ph_q == rcx_pkg::PH_READ;
    wire       ph_wr   = ph_q == rcx_pkg::PH_WRITE;
    wire       do_rd   = ph_rd && is_alu;
    wire       do_wr   = ph_wr && wb_file;
    wire [1:0] pa      = status_q[rcx_pkg::ST_PA_LO +: 2];
    // ************************************************
    // ALU
    // ************************************************
    logic [7:0] alu_res;
    logic [2:0] alu_flg;
    logic [2:0] alu_msk;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] addend;
    always_comb begin
        addend  = (alu_op == rcx_pkg::ALU_SUB) ? ~w_q : w_q;
        sum9    = 9'({1'b0, alu_b} + {1'b0, addend} + 9'(alu_op == rcx_pkg::ALU_SUB));
        sum5    = 5'({1'b0, alu_b[3:0]} + {1'b0, addend[3:0]}
                  + 5'(alu_op == rcx_pkg::ALU_SUB));
        alu_res = alu_b;
        alu_flg = {1'b0, sum5[4], sum9[8]};
        alu_msk = 3'h4;
        case (alu_op)
            rcx_pkg::ALU_MOVWF: begin
                alu_res = w_q;
                alu_msk = 3'h0;
            end
            rcx_pkg::ALU_CLR: alu_res = 8'h00;
            rcx_pkg::ALU_SUB, rcx_pkg::ALU_ADD: begin
                alu_res = sum9[7:0];
                alu_msk = 3'h7;
            end
            rcx_pkg::ALU_DEC:  alu_res = 8'(alu_b - 1'b1);
            rcx_pkg::ALU_INC:  alu_res = 8'(alu_b + 1'b1);
            rcx_pkg::ALU_IOR:  alu_res = alu_b | w_q;
            rcx_pkg::ALU_AND:  alu_res = alu_b & w_q;
            rcx_pkg::ALU_XOR:  alu_res = alu_b ^ w_q;
            rcx_pkg::ALU_COM:  alu_res = ~alu_b;
            rcx_pkg::ALU_MOV:  alu_msk = is_lit ? 3'h0 : 3'h4;
            rcx_pkg::ALU_RR: begin
                alu_res = {status_q[rcx_pkg::ST_C], alu_b[7:1]};
                alu_flg = {2'b00, alu_b[0]};
                alu_msk = 3'h1;
            end
            rcx_pkg::ALU_RL: begin
                alu_res = {alu_b[6:0], status_q[rcx_pkg::ST_C]};
                alu_flg = {2'b00, alu_b[7]};
                alu_msk = 3'h1;
            end
            rcx_pkg::ALU_SWAP: begin
                alu_res = {alu_b[3:0], alu_b[7:4]};
                alu_msk = 3'h0;
            end
            default: alu_msk = 3'h0;
        endcase
        alu_flg[2] = alu_res == 8'h00;
    end
    // Flags only move for instructions that really ran through the ALU.
    wire [2:0] flg_en  = (is_alu || is_lit) ? alu_msk : 3'h0;
    wire [7:0] st_wr   = (wb_file && at_st) ? res_q : status_q;
    wire [7:0] st_next = {st_wr[7:3], (flg_en & flg_q) | (~flg_en & st_wr[2:0])};
    // ************************************************
    // Phase sequencer
    // ************************************************
    // one phase per edge
    always_comb begin
        unique case (ph_q)
            rcx_pkg::PH_DECODE:  ph_d = rcx_pkg::PH_READ;
            rcx_pkg::PH_READ:    ph_d = rcx_pkg::PH_PROCESS;
            rcx_pkg::PH_PROCESS: ph_d = rcx_pkg::PH_WRITE;
            rcx_pkg::PH_WRITE:   ph_d = rcx_pkg::PH_DECODE;
        endcase
    end
    wire wake = periph_irq || tb_ovf;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q    <= rcx_pkg::PH_DECODE;
            sleep_q <= 1'b0;
        end else begin
            ph_q    <= sleep_q ? ph_q : ph_d;
            sleep_q <= !wake && (sleep_q || (ph_wr && is_slp));
        end
    end
    // ************************************************
    // Program counter and fetch
    // ************************************************
    // call reaches lower half
    assign pc_d = is_goto ? {pa, ir_q[8:0]} :
                  is_call ? {pa, 1'b0, lit} :
                  (is_ret || is_rlw) ? stk_top[10:0] :
                  11'(pc_q + 1'b1);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= rcx_pkg::RESET_VECTOR;
            ir_q <= rcx_pkg::OP_NOP;
        end else if (ph_wr) begin
            pc_q <= pc_d;
            ir_q <= branch ? rcx_pkg::OP_NOP : prog_rdata;
        end
    end
    assign prog_addr    = pc_q;
    assign prog_ram_sel = pc_q[10:9] == rcx_pkg::RAM_BLOCK;
    rcx_stack u_stack (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .push      (ph_wr && is_call),
        .pop       (ph_wr && (is_ret || is_rlw)),
        .push_data ({1'b0, pc_q}),
        .top       (stk_top)
    );
    // ************************************************
    // Data path by phase
    // ************************************************
    // decode, read, process stages
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_q  <= '0;
            opnd_q <= '0;
            res_q  <= '0;
            flg_q  <= '0;
        end else begin
            if (ph_q == rcx_pkg::PH_DECODE) begin
                eff_q <= {fsp_q[7:5], fa_dec};
            end
            if (ph_rd) begin
                opnd_q <= at_ta  ? ta_count :
                          at_pc  ? pc_q[7:0] :
                          at_st  ? status_q :
                          at_fsp ? fsp_q :
                          at_per ? periph_rdata : dmem_rdata;
            end
            if (ph_q == rcx_pkg::PH_PROCESS) begin
                res_q <= alu_res;
                flg_q <= alu_flg;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_q      <= '0;
            fsp_q    <= rcx_pkg::FSP_RESET;
            status_q <= rcx_pkg::STATUS_RESET;
            cfg_q    <= rcx_pkg::CFG_RESET;
        end else if (ph_wr) begin
            if (wb_w) begin
                w_q <= res_q;
            end else if (is_rlw) begin
                w_q <= lit;
            end
            if (is_opt) begin
                cfg_q <= w_q;
            end
            if (wb_file && at_fsp) begin
                fsp_q <= res_q;
            end
            status_q <= st_next;
        end
    end
    // ************************************************
    // Memory and peripheral ports
    // ************************************************
    assign dmem_req.addr    = eff_q;
    assign dmem_req.rd      = do_rd && !at_int;
    assign dmem_req.wr      = do_wr && !at_int;
    assign dmem_req.wdata   = res_q;
    assign periph_req.addr  = eff_q;
    assign periph_req.rd    = do_rd && at_per;
    assign periph_req.wr    = do_wr && at_per;
    assign periph_req.wdata = res_q;
    // ************************************************
    // Timers, sleep and oscillator
    // ************************************************
    rcx_timers u_timers (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .cfg               (cfg_q),
        .osc_div4_en       (ph_wr && !sleep_q),
        .ta_load           (do_wr && at_ta),
        .ta_load_val       (res_q),
        .timer_a_count_pin (timer_a_count_pin),
        .clk_32k_pin       (clk_32k_pin),
        .ta_count          (ta_count),
        .tb_ovf            (tb_ovf)
    );
    assign timer_b_irq = tb_ovf && !cfg_q.timer_b_irq_mask
                         && !status_q[rcx_pkg::ST_IRQ_OFF];
    assign osc_run     = !sleep_q || cfg_q.osc_in_sleep || smb_slave_busy;
    assign sleeping    = sleep_q;
endmodule
`default_nettype wire

// >>> rcx_pkg.sv
// Purpose: Shared constants and types for the 8-bit core and its timers.
// Assumes: One clock, sys_clk, which is the instruction oscillator.
// Notes:   File addresses are five-bit offsets inside a data page.
`default_nettype none
package rcx_pkg;
    // ************************************************
    // Widths and reset values
    // ************************************************
    localparam int          PC_W         = 11;
    localparam int          STK_W        = 12;
    localparam int          STK_DEPTH    = 8;
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [7:0]  CFG_RESET    = 8'hff;
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [7:0]  FSP_RESET    = 8'h00;
    // ************************************************
    // File addresses handled inside the core
    // ************************************************
    localparam logic [4:0]  FA_INDIRECT  = 5'h00;
    localparam logic [4:0]  FA_TIMER_A   = 5'h01;
    localparam logic [4:0]  FA_PC_LOW    = 5'h02;
    localparam logic [4:0]  FA_STATUS    = 5'h03;
    localparam logic [4:0]  FA_FSP       = 5'h04;
    localparam logic [4:0]  FA_PERIPH    = 5'h06;
    // Status bit positions.
    localparam int          ST_C         = 0;
    localparam int          ST_DC        = 1;
    localparam int          ST_Z         = 2;
    localparam int          ST_PA_LO     = 5;
    localparam int          ST_IRQ_OFF   = 7;
    // Program block that holds writable memory.
    localparam logic [1:0]  RAM_BLOCK    = 2'h1;
    // ************************************************
    // Instruction encodings
    // ************************************************
    localparam logic [11:0] OP_NOP       = 12'h000;
    localparam logic [11:0] OP_OPTION    = 12'h002;
    localparam logic [11:0] OP_SLEEP     = 12'h003;
    localparam logic [11:0] OP_RETURN    = 12'h008;
    localparam logic [3:0]  OP4_RETURN_WITH_LITERAL    = 4'h8;
    localparam logic [3:0]  OP4_CALL     = 4'h9;
    localparam logic [2:0]  OP3_GOTO     = 3'h5;
    localparam logic [3:0]  OP4_FILE_TOP = 4'h3;
    localparam logic [3:0]  OP4_MOVLW    = 4'hc;
    localparam logic [3:0]  OP4_IORLW    = 4'hd;
    localparam logic [3:0]  OP4_ANDLW    = 4'he;
    localparam logic [5:0]  ALU_MOVWF    = 6'h00;
    localparam logic [5:0]  ALU_CLR      = 6'h01;
    localparam logic [5:0]  ALU_SUB      = 6'h02;
    localparam logic [5:0]  ALU_DEC      = 6'h03;
    localparam logic [5:0]  ALU_IOR      = 6'h04;
    localparam logic [5:0]  ALU_AND      = 6'h05;
    localparam logic [5:0]  ALU_XOR      = 6'h06;
    localparam logic [5:0]  ALU_ADD      = 6'h07;
    localparam logic [5:0]  ALU_MOV      = 6'h08;
    localparam logic [5:0]  ALU_COM      = 6'h09;
    localparam logic [5:0]  ALU_INC      = 6'h0a;
    localparam logic [5:0]  ALU_RR       = 6'h0c;
    localparam logic [5:0]  ALU_RL       = 6'h0d;
    localparam logic [5:0]  ALU_SWAP     = 6'h0e;
    // ************************************************
    // Timer codes
    // ************************************************
    localparam logic [1:0]  TAS_PIN_FALL = 2'h0;
    localparam logic [1:0]  TAS_PIN_RISE = 2'h1;
    localparam logic [1:0]  TAS_CLK32    = 2'h2;
    localparam logic [1:0]  TAS_OSC_DIV4 = 2'h3;
    localparam logic [2:0]  TB_RESERVED  = 3'h7;
    localparam logic [15:0] TB_BASE      = 16'h0200;
    // ************************************************
    // Types
    // ************************************************
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rcx_phase_e;
    typedef struct packed {
        logic       osc_in_sleep;
        logic       timer_a_disable;
        logic [1:0] timer_a_source;
        logic       timer_b_irq_mask;
        logic [2:0] timer_b_period;
    } rcx_cfg_s;
    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } rcx_dreq_s;
endpackage
`default_nettype wire

// >>> rcx_stack.sv
// Purpose: Circular return-address stack with a registered top word.
// Assumes: Push and pop are never asserted together.
// Notes:   Depth must be a power of two so the pointer wraps by itself.
`default_nettype none
module rcx_stack #(
    parameter int DEPTH = rcx_pkg::STK_DEPTH,
    parameter int W     = rcx_pkg::STK_W
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Stack access
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_data,
    output logic      [W-1:0] top
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("Stack depth must be a power of two.");
    end
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] ptr_q;
    logic [W-1:0]  top_q;
    wire  [AW-1:0] below = AW'(ptr_q - AW'(2));
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[ptr_q] <= push_data;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= '0;
            top_q <= '0;
        end else if (push) begin
            ptr_q <= AW'(ptr_q + 1'b1);
            top_q <= push_data;
        end else if (pop) begin
            ptr_q <= AW'(ptr_q - 1'b1);
            top_q <= mem[below];
        end
    end
    assign top = top_q;
endmodule
`default_nettype wire

// >>> rcx_timers.sv
// Purpose: Timer A event counter and timer B periodic overflow.
// Assumes: Both count pins are asynchronous to sys_clk.
// Notes:   Timer B is held at zero on the reserved period code.
`default_nettype none
module rcx_timers (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Control
    input  wire rcx_pkg::rcx_cfg_s cfg,
    input  wire logic             osc_div4_en,
    input  wire logic             ta_load,
    input  wire logic [7:0]       ta_load_val,
    // Pins
    input  wire logic             timer_a_count_pin,
    input  wire logic             clk_32k_pin,
    // Results
    output logic      [7:0]       ta_count,
    output logic                  tb_ovf
);
    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [1:0]  s1_q, s2_q, s3_q, stable_q;
    logic [7:0]  ta_q;
    logic [15:0] tb_q;
    logic        tb_ovf_q;
    wire  [1:0]  agree = ~(s2_q ^ s3_q);
    wire  [1:0]  rise  = agree & s3_q & ~stable_q;
    wire  [1:0]  fall  = agree & ~s3_q & stable_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            stable_q <= '0;
        end else begin
            s1_q     <= {clk_32k_pin, timer_a_count_pin};
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= (agree & s3_q) | (~agree & stable_q);
        end
    end
    // ************************************************
    // Timer A
    // ************************************************
    // select increment event
    wire ta_evt = (cfg.timer_a_source == rcx_pkg::TAS_PIN_FALL) ? fall[0] :
                  (cfg.timer_a_source == rcx_pkg::TAS_PIN_RISE) ? rise[0] :
                  (cfg.timer_a_source == rcx_pkg::TAS_CLK32)    ? rise[1] :
                  osc_div4_en;
    wire ta_inc = ta_evt && !cfg.timer_a_disable;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ta_q <= '0;
        end else if (ta_load) begin
            ta_q <= ta_load_val;
        end else if (ta_inc) begin
            ta_q <= 8'(ta_q + 1'b1);
        end
    end
    // ************************************************
    // Timer B
    // ************************************************
    // period of 256 times 2^(n+1)
    wire [15:0] tb_last = 16'((rcx_pkg::TB_BASE << cfg.timer_b_period) - 16'h0001);
    wire        tb_run  = cfg.timer_b_period != rcx_pkg::TB_RESERVED;
    wire        tb_wrap = tb_run && rise[1] && (tb_q >= tb_last);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_q     <= '0;
            tb_ovf_q <= 1'b0;
        end else begin
            tb_ovf_q <= tb_wrap;
            if (!tb_run || tb_wrap) begin
                tb_q <= '0;
            end else if (rise[1]) begin
                tb_q <= 16'(tb_q + 1'b1);
            end
        end
    end
    assign ta_count = ta_q;
    assign tb_ovf   = tb_ovf_q;
endmodule
`default_nettype wire

// >>> rcx_asserts.sv
// Purpose: Port-level checks for the core.
// Assumes: Sees only the ports of rcx_core.
// Notes:   Strobes are one-cycle pulses.
`default_nettype none
module rcx_asserts (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Buses
    input wire logic [10:0]        prog_addr,
    input wire logic               prog_ram_sel,
    input wire rcx_pkg::rcx_dreq_s dmem_req,
    input wire rcx_pkg::rcx_dreq_s periph_req,
    // Power
    input wire logic               smb_slave_busy,
    input wire logic               osc_run,
    input wire logic               sleeping
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_ram_sel; prog_ram_sel == (prog_addr[10:9] == 2'h1); endproperty
    a_ram_sel: assert property (p_ram_sel) else $error("ram select wrong");
    property p_pc_hold; $changed(prog_addr) |=> $stable(prog_addr)[*3]; endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved early");
    property p_wr_once; dmem_req.wr |=> !dmem_req.wr[*3]; endproperty
    a_wr_once: assert property (p_wr_once) else $error("second write");
    property p_rd_once; dmem_req.rd |=> !dmem_req.rd[*3]; endproperty
    a_rd_once: assert property (p_rd_once) else $error("second read");
    property p_addr_hold; dmem_req.rd |=> $stable(dmem_req.addr)[*2]; endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_internal;
        dmem_req.wr |-> !(dmem_req.addr[4:0] inside {5'h01, 5'h02, 5'h03, 5'h04});
    endproperty
    a_internal: assert property (p_internal) else $error("internal file on bus");
    property p_periph; (periph_req.rd || periph_req.wr) |-> periph_req.addr[4:0] == 5'h06;
    endproperty
    a_periph: assert property (p_periph) else $error("port address wrong");
    property p_awake; !sleeping |-> osc_run; endproperty
    a_awake: assert property (p_awake) else $error("oscillator off awake");
    property p_smb; smb_slave_busy |-> osc_run; endproperty
    a_smb: assert property (p_smb) else $error("oscillator off in transfer");
endmodule
`default_nettype wire

// >>> rcx_mem.sv
// Purpose: Program and data memory beside the core.
// Assumes: Same-cycle answers.
// Notes:   Unselected dmem_rdata is inverted so stale values never pass; periph_rdata is always the inverted address.
`default_nettype none
module rcx_mem (
    input  wire logic               sys_clk,
    input  wire logic [10:0]        prog_addr,
    input  wire rcx_pkg::rcx_dreq_s dmem_req,
    input  wire rcx_pkg::rcx_dreq_s periph_req,
    output logic      [11:0]        prog_rdata,
    output logic      [7:0]         dmem_rdata,
    output logic      [7:0]         periph_rdata
);
    logic [7:0] mem_q [256];
    always_comb begin
        case (prog_addr)
            11'h000: prog_rdata = 12'hc5a;
            11'h001: prog_rdata = 12'h030;
            11'h002: prog_rdata = 12'h908;
            11'h003: prog_rdata = 12'h031;
            11'h004: prog_rdata = 12'h1f0;
            11'h005: prog_rdata = 12'ha09;
            11'h008: prog_rdata = 12'h83c;
            11'h009: prog_rdata = 12'hc37;
            11'h00a: prog_rdata = 12'h002;
            11'h00d: prog_rdata = 12'h201;
            11'h00e: prog_rdata = 12'h032;
            11'h00f: prog_rdata = 12'h003;
            default: prog_rdata = rcx_pkg::OP_NOP;
        endcase
    end
    assign dmem_rdata = dmem_req.rd ? mem_q[dmem_req.addr] : ~mem_q[dmem_req.addr];
    assign periph_rdata = ~periph_req.addr;
    always_ff @(posedge sys_clk) if (dmem_req.wr) mem_q[dmem_req.addr] <= dmem_req.wdata;
endmodule
`default_nettype wire

// >>> rcx_core_tb.sv
// Purpose: Runs a short program and checks the data writes.
// Assumes: Program held in rcx_mem.
// Notes:   Gaps of the writes expose pipeline refills.
`default_nettype none
module rcx_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] EXP_VAL [4] = '{16'h105a, 16'h113c, 16'h1096, 16'h1202};
    localparam logic [15:0] EXP_GAP [4] = '{16'h0000, 16'h0014, 16'h0018, 16'h0038};
    logic sys_clk, rst_n, smb_slave_busy, prog_ram_sel, osc_run, sleeping, timer_b_irq;
    logic [10:0] prog_addr;
    logic [11:0] prog_rdata;
    logic [7:0] dmem_rdata, periph_rdata;
    rcx_pkg::rcx_dreq_s dmem_req, periph_req;
    int failures, comparisons, cyc, wr_cyc[$];
    logic [15:0] wr_val[$];
    rcx_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_ram_sel(prog_ram_sel), .prog_rdata(prog_rdata), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata), .periph_req(periph_req), .periph_rdata(periph_rdata),
        .periph_irq(1'b0), .smb_slave_busy(smb_slave_busy), .timer_a_count_pin(1'b0),
        .clk_32k_pin(1'b0), .osc_run(osc_run), .sleeping(sleeping),
        .timer_b_irq(timer_b_irq));
    rcx_mem mem_u (.sys_clk(sys_clk), .prog_addr(prog_addr), .dmem_req(dmem_req),
        .periph_req(periph_req), .prog_rdata(prog_rdata), .dmem_rdata(dmem_rdata),
        .periph_rdata(periph_rdata));
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // A hung core must still reach the verdict.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            print_verdict();
        end
    end
    always @(negedge sys_clk) if (rst_n === 1'b1 && dmem_req.wr === 1'b1) begin
        wr_cyc.push_back(cyc);
        wr_val.push_back({dmem_req.addr, dmem_req.wdata});
    end
    initial begin
        rst_n = 1'b0;
        smb_slave_busy = 1'b0;
        failures = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (120) @(posedge sys_clk);
        check("write count", 16'(wr_val.size()), 16'h0004);
        for (int i = 0; i < 4; i++) begin
            check("write data", wr_val[i], EXP_VAL[i]);
            check("write gap", 16'(wr_cyc[i] - wr_cyc[0]), EXP_GAP[i]);
        end
        check("timer a read", wr_val[3], 16'h1202);
        $display("program test done");
        @(negedge sys_clk);
        check("osc stopped", {15'h0000, osc_run}, 16'h0000);
        check("sleeping", {15'h0000, sleeping}, 16'h0001);
        @(posedge sys_clk);
        smb_slave_busy <= 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check("osc run", {15'h0000, osc_run}, 16'h0001);
        $display("oscillator test done");
        print_verdict();
    end
endmodule
bind rcx_core rcx_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_ram_sel(prog_ram_sel), .dmem_req(dmem_req), .periph_req(periph_req),
    .smb_slave_busy(smb_slave_busy), .osc_run(osc_run), .sleeping(sleeping));
`default_nettype wire
